// *** hw/strobe_port_pkg.sv ***
// constants for the four-pin chip-select strobe port
package strobe_port_pkg;
  localparam int NUM_PINS = 4;
  // special function register addresses
  localparam logic [7:0] ADDR_CTRL_LOW = 8'h92;
  localparam logic [7:0] ADDR_CTRL_HIGH = 8'h93;
  localparam logic [7:0] ADDR_POLARITY_MISC = 8'ha2;
  localparam logic [7:0] ADDR_PORT_DATA = 8'ha5;
  // base-address registers have no printed address; chosen slots
  localparam logic [7:0] ADDR_BASE_FIRST = 8'hb0;
  // function select codes
  localparam logic [1:0] FUNC_GPIO = 2'h0;
  localparam logic [1:0] FUNC_READ = 2'h1;
  localparam logic [1:0] FUNC_WRITE = 2'h2;
  localparam logic [1:0] FUNC_READ_WRITE = 2'h3;
  // compare width codes
  localparam logic [1:0] CMP_FULL = 2'h0;
  localparam logic [1:0] CMP_A15_A1 = 2'h1;
  localparam logic [1:0] CMP_A15_A2 = 2'h2;
  localparam logic [1:0] CMP_A15_A8 = 2'h3;
  // field positions inside one pin's control nibble
  localparam int FUNC_LSB = 2;
  localparam int CMP_LSB = 0;
  // polarity / misc register fields
  localparam int POL_LSB = 4;
  localparam int PWDN_HOLD_BIT = 2;
  localparam int RMW_PIN_BIT = 1;
  localparam int P0_PULLUP_BIT = 0;
  // reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] BASE_RESET = 8'h00;
  localparam logic [7:0] MISC_RESET = 8'h00;
  localparam logic [3:0] DATA_RESET = 4'hf;
endpackage : strobe_port_pkg

// *** hw/strobe_cfg_if.sv ***
// configuration handed from the register file to the address matcher
`timescale 1ns/100ps
interface strobe_cfg_if;
  logic [15:0] base [4];
  logic [1:0] width [4];
  logic [15:0] bus_addr;
  logic [3:0] hit;
  modport regs (output base, output width, output bus_addr, input hit);
  modport match (input base, input width, input bus_addr, output hit);
endinterface : strobe_cfg_if

// *** hw/strobe_addr_match.sv ***
// per-pin masked compare of the external bus address against its base
`timescale 1ns/100ps
module strobe_addr_match
  import strobe_port_pkg::*;
(
  strobe_cfg_if.match cfg
);
  for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
    logic [15:0] mask;
    always_comb begin
      case (cfg.width[p])
        CMP_FULL: mask = 16'hffff; // [RL5]
        CMP_A15_A1: mask = 16'hfffe; // [RL6]
        CMP_A15_A2: mask = 16'hfffc; // [RL7]
        CMP_A15_A8: mask = 16'hff00; // [RL8]
        default: mask = 16'hffff;
      endcase
    end
    assign cfg.hit[p] = ((cfg.bus_addr ^ cfg.base[p]) & mask) == 16'h0000;
  end
endmodule : strobe_addr_match

// *** hw/port_chip_select_strobe.sv ***
// four-pin port: quasi-bidirectional i/o or address-decoded chip selects
// Behaviour
// (RL1) function 00: plain quasi-bidirectional port pin
// (RL2) function 01: strobe on matching external reads
// (RL3) function 10: strobe on matching external writes
// (RL4) function 11: strobe on matching reads and writes
// (RL5) compare width 00: all sixteen bits
// (RL6) compare width 01: bits 15 to 1
// (RL7) compare width 10: bits 15 to 2
// (RL8) compare width 11: bits 15 to 8
// (RL9) each pin has high and low base bytes
// (RL10) polarity bit set gives active-high strobe
// (RL11) power-down hold bit picks strobe idle level
// (RL12) rmw read takes pin or latch
// (RL13) pull-up bit enables port zero pull-ups
// (RL14) data register bits 3:0 drive pins
// (RL15) matching write strobes; gpio follows data
// (RL16) high-pins control register field layout
// (RL17) strobe only during matching bus phase; the registered strobe here follows the phase one clock later
// (RL18) config resets zero, data latch ones
`timescale 1ns/100ps
module port_chip_select_strobe
  import strobe_port_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset,
  // special function register port
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic i_sfr_rd,
  input wire logic i_sfr_rmw,
  output logic [7:0] o_sfr_rdata,
  // external data bus phases
  input wire logic [15:0] i_xdata_addr,
  input wire logic i_xdata_rd_phase,
  input wire logic i_xdata_wr_phase,
  // power-down state of the cpu
  input wire logic i_power_down,
  // pins
  input wire logic [3:0] i_pin,
  output logic [3:0] o_pin,
  output logic [3:0] o_pin_oe_n,
  output logic o_ale_pd_level,
  output logic o_program_store_strobe_pd_level,
  output logic o_port_zero_pullup_en
);
  logic [7:0] ctrl_low_r, ctrl_low_nxt;
  logic [7:0] ctrl_high_r, ctrl_high_nxt;
  logic [7:0] misc_r, misc_nxt;
  logic [3:0] data_r, data_nxt;
  logic [7:0] base_high_r [4];
  logic [7:0] base_low_r [4];
  logic [7:0] base_high_nxt [4];
  logic [7:0] base_low_nxt [4];
  logic [3:0] pin_nxt, oe_n_nxt;
  logic [7:0] rdata_nxt;
  logic ale_nxt, pss_nxt, pup_nxt;
  logic [15:0] ctrl_all;

  strobe_cfg_if cfg ();

  strobe_addr_match u_match (
    .cfg(cfg)
  );

  assign ctrl_all = {ctrl_high_r, ctrl_low_r};
  assign cfg.bus_addr = i_xdata_addr;

  for (genvar p = 0; p < NUM_PINS; p++) begin : g_cfg
    assign cfg.base[p] = {base_high_r[p], base_low_r[p]}; // [RL9]
    assign cfg.width[p] = ctrl_all[4*p+CMP_LSB +: 2];
  end

  // register writes
  always_comb begin
    ctrl_low_nxt = ctrl_low_r;
    ctrl_high_nxt = ctrl_high_r;
    misc_nxt = misc_r;
    data_nxt = data_r;
    base_high_nxt = base_high_r;
    base_low_nxt = base_low_r;
    if (i_sfr_wr) begin
      case (i_sfr_addr)
        ADDR_CTRL_LOW: ctrl_low_nxt = i_sfr_wdata;
        ADDR_CTRL_HIGH: ctrl_high_nxt = i_sfr_wdata; // [RL16]
        ADDR_POLARITY_MISC: misc_nxt = i_sfr_wdata & 8'hf7;
        ADDR_PORT_DATA: data_nxt = i_sfr_wdata[3:0]; // [RL14]
        default: begin
          for (int p = 0; p < NUM_PINS; p++) begin
            if (i_sfr_addr == ADDR_BASE_FIRST + 8'(2*p))
              base_high_nxt[p] = i_sfr_wdata; // [RL9]
            if (i_sfr_addr == ADDR_BASE_FIRST + 8'(2*p+1))
              base_low_nxt[p] = i_sfr_wdata; // [RL9]
          end
        end
      endcase
    end
  end

  // register reads; rmw reads of the port pick pin or latch
  always_comb begin
    rdata_nxt = 8'h00;
    if (i_sfr_rd) begin
      case (i_sfr_addr)
        ADDR_CTRL_LOW: rdata_nxt = ctrl_low_r;
        ADDR_CTRL_HIGH: rdata_nxt = ctrl_high_r;
        ADDR_POLARITY_MISC: rdata_nxt = misc_r;
        ADDR_PORT_DATA: begin
          if (i_sfr_rmw && !misc_r[RMW_PIN_BIT])
            rdata_nxt = {4'h0, data_r}; // [RL12]
          else
            rdata_nxt = {4'h0, i_pin}; // [RL12] [RL14]
        end
        default: begin
          for (int p = 0; p < NUM_PINS; p++) begin
            if (i_sfr_addr == ADDR_BASE_FIRST + 8'(2*p))
              rdata_nxt = base_high_r[p];
            if (i_sfr_addr == ADDR_BASE_FIRST + 8'(2*p+1))
              rdata_nxt = base_low_r[p];
          end
        end
      endcase
    end
  end

  // pin drive: quasi-bidirectional gpio drives only low strongly;
  // a one is left to the pull-up so external logic can pull low
  always_comb begin
    for (int p = 0; p < NUM_PINS; p++) begin
      logic [1:0] func;
      logic active;
      func = ctrl_all[4*p+FUNC_LSB +: 2];
      active = 1'b0;
      case (func)
        FUNC_READ: active = cfg.hit[p] && i_xdata_rd_phase; // [RL2] [RL17]
        FUNC_WRITE: active = cfg.hit[p] && i_xdata_wr_phase; // [RL3] [RL15]
        FUNC_READ_WRITE:
          active = cfg.hit[p] && (i_xdata_rd_phase || i_xdata_wr_phase); // [RL4]
        default: active = 1'b0;
      endcase
      if (func == FUNC_GPIO) begin
        pin_nxt[p] = data_r[p]; // [RL1] [RL15]
        oe_n_nxt[p] = data_r[p]; // [RL1]
      end else begin
        // strobe pins are driven both ways at the chosen polarity
        pin_nxt[p] = misc_r[POL_LSB+p] ? active : !active; // [RL10]
        oe_n_nxt[p] = 1'b0;
      end
    end
    ale_nxt = i_power_down ? misc_r[PWDN_HOLD_BIT] : 1'b1; // [RL11]
    pss_nxt = i_power_down ? misc_r[PWDN_HOLD_BIT] : 1'b1; // [RL11]
    pup_nxt = misc_r[P0_PULLUP_BIT]; // [RL13]
  end

  // outputs lag the bus phase by one clock: all outputs are registered
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      ctrl_low_r <= CTRL_RESET; // [RL18]
      ctrl_high_r <= CTRL_RESET; // [RL18]
      misc_r <= MISC_RESET; // [RL18]
      data_r <= DATA_RESET; // [RL18]
      for (int p = 0; p < NUM_PINS; p++) begin
        base_high_r[p] <= BASE_RESET; // [RL18]
        base_low_r[p] <= BASE_RESET;
      end
      o_sfr_rdata <= 8'h00;
      o_pin <= DATA_RESET;
      o_pin_oe_n <= 4'hf;
      o_ale_pd_level <= 1'b1;
      o_program_store_strobe_pd_level <= 1'b1;
      o_port_zero_pullup_en <= 1'b0;
    end else begin
      ctrl_low_r <= ctrl_low_nxt;
      ctrl_high_r <= ctrl_high_nxt;
      misc_r <= misc_nxt;
      data_r <= data_nxt;
      base_high_r <= base_high_nxt;
      base_low_r <= base_low_nxt;
      o_sfr_rdata <= rdata_nxt;
      o_pin <= pin_nxt;
      o_pin_oe_n <= oe_n_nxt;
      o_ale_pd_level <= ale_nxt;
      o_program_store_strobe_pd_level <= pss_nxt;
      o_port_zero_pullup_en <= pup_nxt;
    end
  end
endmodule : port_chip_select_strobe

// *** verif/strobe_port_checker.sv ***
// concurrent checks on the strobe port pins and register reads
`timescale 1ns/100ps
module strobe_port_checker
  import strobe_port_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic i_sfr_rd,
  input wire logic [7:0] o_sfr_rdata,
  input wire logic i_xdata_rd_phase,
  input wire logic i_xdata_wr_phase,
  input wire logic i_power_down,
  input wire logic [3:0] o_pin,
  input wire logic [3:0] o_pin_oe_n,
  input wire logic o_ale_pd_level,
  input wire logic o_program_store_strobe_pd_level,
  input wire logic o_port_zero_pullup_en
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  misc_gap_a: assert property (
    i_sfr_rd && i_sfr_addr == ADDR_POLARITY_MISC |=> !o_sfr_rdata[3])
    else $error("unused polarity bit read as one");
  pullup_follow_a: assert property (
    i_sfr_wr && i_sfr_addr == ADDR_POLARITY_MISC |-> ##2
    o_port_zero_pullup_en == $past(i_sfr_wdata[P0_PULLUP_BIT], 2))
    else $error("pull-up enable not following its bit");
  pd_release_a: assert property (
    !i_power_down |=> o_ale_pd_level && o_program_store_strobe_pd_level)
    else $error("bus strobes forced outside power-down");
  pd_pair_a: assert property (
    o_ale_pd_level == o_program_store_strobe_pd_level)
    else $error("latch and store strobe levels differ");
  hold_level_a: assert property (
    i_sfr_wr && i_sfr_addr == ADDR_POLARITY_MISC ##1 i_power_down [*2]
    |-> o_ale_pd_level == $past(i_sfr_wdata[PWDN_HOLD_BIT], 2))
    else $error("power-down strobe level wrong");
  gpio_high_a: assert property ((o_pin_oe_n & ~o_pin) == 4'h0)
    else $error("released pin shows low output");
  strobe_drive_a: assert property (
    i_sfr_wr && i_sfr_addr == ADDR_CTRL_LOW && i_sfr_wdata[3:2] != FUNC_GPIO
    |-> ##2 !o_pin_oe_n[0])
    else $error("strobe pin not driven");
  pin_cause_a: assert property ($changed(o_pin) |->
    $past(i_sfr_wr, 2) || $past(i_xdata_rd_phase | i_xdata_wr_phase) ||
    $past(i_xdata_rd_phase | i_xdata_wr_phase, 2))
    else $error("pin changed without bus cycle or write");
  cover property (i_xdata_wr_phase ##1 !o_pin_oe_n[2]);
  cover property (i_xdata_rd_phase ##1 !o_pin_oe_n[2]);
  cover property (i_power_down && !o_ale_pd_level);
endmodule : strobe_port_checker
bind port_chip_select_strobe strobe_port_checker u_strobe_port_checker (.*);

// *** verif/strobe_peripheral.sv ***
// far side of the port: pull-ups and a device that may sink a pin
`timescale 1ns/100ps
module strobe_peripheral (
  input wire logic [3:0] i_pin_out,
  input wire logic [3:0] i_pin_oe_n,
  input wire logic [3:0] i_pull_low,
  output logic [3:0] o_pin_level
);
  // a released pin floats up; sinking wins over any drive
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      o_pin_level[i] = i_pin_oe_n[i] ? 1'b1 : i_pin_out[i];
      if (i_pull_low[i]) o_pin_level[i] = 1'b0;
    end
  end
endmodule : strobe_peripheral

// *** verif/tb_top.sv ***
// register-level bench for the chip-select strobe port
`timescale 1ns/100ps
module tb_top
  import strobe_port_pkg::*;
;
  logic i_clk, i_reset, wr, rd, rmw, rph, wph, pd, pol, act;
  logic [7:0] addr, wdata, rdata, d, a, v;
  logic [15:0] xa;
  logic [3:0] pin, opin, oe_n, pull;
  logic ale, pss, pup;
  int bad_count, total_checks, cyc;
  port_chip_select_strobe u_port_chip_select_strobe (.i_clk(i_clk),
    .i_reset(i_reset), .i_sfr_addr(addr), .i_sfr_wr(wr), .i_sfr_wdata(wdata),
    .i_sfr_rd(rd), .i_sfr_rmw(rmw), .o_sfr_rdata(rdata), .i_xdata_addr(xa),
    .i_xdata_rd_phase(rph), .i_xdata_wr_phase(wph), .i_power_down(pd),
    .i_pin(pin), .o_pin(opin), .o_pin_oe_n(oe_n), .o_ale_pd_level(ale),
    .o_program_store_strobe_pd_level(pss), .o_port_zero_pullup_en(pup));
  strobe_peripheral u_strobe_peripheral (.i_pin_out(opin),
    .i_pin_oe_n(oe_n), .i_pull_low(pull), .o_pin_level(pin));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wreg(input logic [7:0] ad, input logic [7:0] dt);
    @(negedge i_clk);
    addr = ad;
    wdata = dt;
    wr = 1'b1;
    @(negedge i_clk);
    wr = 1'b0;
  endtask : wreg
  task automatic rreg(input logic [7:0] ad, input logic m);
    @(negedge i_clk);
    addr = ad;
    rmw = m;
    rd = 1'b1;
    @(negedge i_clk);
    rd = 1'b0;
    d = rdata;
  endtask : rreg
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : finish_test
  // the three control registers first, then the eight base bytes
  function automatic logic [7:0] reg_addr(input int i);
    if (i < 3) return i == 0 ? ADDR_CTRL_LOW :
      (i == 1 ? ADDR_CTRL_HIGH : ADDR_POLARITY_MISC);
    return ADDR_BASE_FIRST + 8'(i - 3);
  endfunction : reg_addr
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      finish_test();
    end
  end
  initial begin
    {i_reset, wr, rd, rmw, rph, wph, pd} = 7'h40;
    {addr, wdata, xa, pull} = '0;
    repeat (2) @(negedge i_clk);
    i_reset = 1'b0;
    chk({opin, oe_n, 1'b0, ale, pss, pup}, 16'h0ff6);
    for (int i = 0; i < 11; i++) begin
      rreg(reg_addr(i), 1'b0);
      chk(d, 0);
    end
    rreg(ADDR_PORT_DATA, 1'b1);
    chk(d[3:0], 4'hf);
    $display("test reset done");
    for (int i = 0; i < 11; i++) begin
      a = reg_addr(i);
      v = 8'ha5 ^ 8'(i);
      wreg(a, v);
      rreg(a, 1'b0);
      chk(d, (i == 2) ? v & 8'hf7 : v);
    end
    $display("test registers done");
    wreg(ADDR_CTRL_LOW, 8'h00);
    wreg(ADDR_CTRL_HIGH, 8'h00);
    wreg(ADDR_POLARITY_MISC, 8'h00);
    wreg(ADDR_PORT_DATA, 8'h05);
    pull = 4'h1;
    repeat (3) @(negedge i_clk);
    chk({opin, oe_n}, 8'h55);
    rreg(ADDR_PORT_DATA, 1'b0);
    chk(d[3:0], 4'h4);
    rreg(ADDR_PORT_DATA, 1'b1);
    chk(d[3:0], 4'h5);
    wreg(ADDR_POLARITY_MISC, 8'h02);
    rreg(ADDR_PORT_DATA, 1'b1);
    chk(d[3:0], 4'h4);
    pull = 4'h0;
    $display("test gpio done");
    wreg(ADDR_BASE_FIRST + 8'h04, 8'h12);
    wreg(ADDR_BASE_FIRST + 8'h05, 8'h34);
    for (int f = 1; f < 4; f++) for (int w = 0; w < 4; w++) begin
      pol = (f == 3);
      wreg(ADDR_CTRL_HIGH, {4'h0, 2'(f), 2'(w)});
      wreg(ADDR_POLARITY_MISC, pol ? 8'h40 : 8'h00);
      @(negedge i_clk);
      for (int k = 0; k < 10; k++) begin
        xa = (k / 2 == 4) ? 16'h1334 : 16'h1234 + 16'(k / 2);
        xa = (k / 2 == 3) ? 16'h12ff : xa;
        rph = (k % 2 == 0);
        wph = (k % 2 == 1);
        act = (k / 2 <= w) && (rph ? f[0] : f[1]);
        @(negedge i_clk);
        chk(opin, {1'b0, pol == act, 2'b01});
        {rph, wph} = 2'b00;
        @(negedge i_clk);
        chk(opin[2], !pol);
      end
    end
    $display("test strobes done");
    pd = 1'b1;
    for (int h = 0; h < 2; h++) begin
      wreg(ADDR_POLARITY_MISC, {5'h0, 1'(h), 2'b01});
      @(negedge i_clk);
      chk({ale, pss, pup}, {1'(h), 1'(h), 1'b1});
    end
    pd = 1'b0;
    repeat (2) @(negedge i_clk);
    chk(ale, 1'b1);
    $display("test power-down done");
    finish_test();
  end
endmodule : tb_top
